// ===== dv/dcc_cke_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_cke_monitor
    import dcc_pkg::*;
(
    // Pins and status
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      reset_n,
    input  wire dcc_cmd_s  cmd,
    input  wire logic      init_done,
    input  wire dcc_stat_s stat
);
    logic       cke_q;
    logic [3:0] op;
    logic       nop;
    logic       up;
    assign op  = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign nop = cmd.cs_n || op == CMD_NOP;
    // Enable high at this edge and the last
    assign up  = cke_q && cmd.cke && !stat.power_down;
    always_ff @(posedge clk) begin
        cke_q <= (rst || !reset_n) ? 1'b0 : cmd.cke;
    end
    // Window length, and the mode it was started in
    logic [CNT_W-1:0] zq_len;
    logic             zq_oper;
    always_ff @(posedge clk) begin
        if (rst || !reset_n || !stat.zq_busy) begin
            zq_len  <= '0;
            zq_oper <= init_done;
        end else begin
            zq_len <= zq_len + 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst || !reset_n);
    property p_pde_pre;
        cke_q && $past(stat.idle) && stat.bank_open == 0 && !stat.zq_busy && !cmd.cke && nop
            |=> {stat.power_down, stat.active_pd} == 2'b10;
    endproperty
    a_pde_pre: assert property (p_pde_pre) else $error("no precharge power-down");
    property p_pde_act;
        cke_q && !cmd.cke && nop && stat.bank_open != 0 && !stat.burst_busy
            && !stat.power_down && !stat.zq_busy |=> stat.power_down && stat.active_pd;
    endproperty
    a_pde_act: assert property (p_pde_act) else $error("no active power-down");
    property p_pd_hold;
        stat.power_down && !cmd.cke |=> stat.power_down;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down lost");
    property p_sre;
        cke_q && $past(stat.idle) && stat.bank_open == 0 && !stat.zq_busy && !cmd.cke
            && op == CMD_REF |=> stat.self_refresh;
    endproperty
    a_sre: assert property (p_sre) else $error("no self refresh");
    property p_sr_exit;
        $past(stat.self_refresh) && cmd.cke && nop |-> !stat.self_refresh
            ##1 (!stat.self_refresh && !stat.power_down);
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh held");
    property p_idle;
        stat.idle |-> cmd.cke && stat.bank_open == 0 && !stat.burst_busy
            && !stat.power_down && !stat.zq_busy;
    endproperty
    a_idle: assert property (p_idle) else $error("idle too early");
    property p_nop;
        nop |=> !stat.mr_we;
    endproperty
    a_nop: assert property (p_nop) else $error("idle command acted");
    property p_mrs;
        up && op == CMD_MRS && stat.bank_open == 0 && !stat.burst_busy && !stat.zq_busy
            |=> stat.mr_we && stat.mr_sel == $past(cmd.ba[1:0])
            && stat.mr_data == $past(cmd.addr);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode write wrong");
    property p_pdx_settle;
        $fell(stat.power_down) && $past(reset_n) && !$past(rst) |-> (!stat.idle) [*4];
    endproperty
    a_pdx_settle: assert property (p_pdx_settle) else $error("idle before exit settle");
    property p_zq_len;
        stat.zq_update |-> zq_len == (zq_oper ? ZQ_OPER_CYC : ZQ_INIT_CYC);
    endproperty
    a_zq_len: assert property (p_zq_len) else $error("calibration window length");
endmodule : dcc_cke_monitor
bind dcc_cke_ctrl dcc_cke_monitor u_dcc_cke_monitor (.clk(clk), .rst(rst),
    .reset_n(reset_n), .cmd(cmd), .init_done(init_done), .stat(stat));
`default_nettype wire

// ===== dv/dcc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_ctl_model
    import dcc_pkg::*;
(
    // Pins toward the device
    input  wire logic     clk,
    output var dcc_cmd_s  cmd,
    output logic          reset_n
);
    int   held;
    logic cke_last;
    initial begin
        cmd      = 22'h3e_0000;
        reset_n  = 1'b1;
        held     = 99;
        cke_last = 1'b1;
    end
    always @(posedge clk) begin
        held     <= (cmd.cke == cke_last) ? held + 1 : 1;
        cke_last <= cmd.cke;
    end
    // Legal encodings only; odt flips to show it is ignored
    task automatic send(input logic [3:0] op, input logic cke, input logic [2:0] ba,
        input logic [12:0] a);
        while (cke !== cmd.cke && held < CKE_MIN_CYC) @(negedge clk);
        cmd = {op, cke, ~cmd.odt, ba, a};
    endtask : send
    task automatic pin_reset;
        @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
    endtask : pin_reset
endmodule : dcc_ctl_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import dcc_pkg::*;
;
    logic      clk;
    logic      rst;
    logic      init_done;
    logic      reset_n;
    dcc_cmd_s  cmd;
    dcc_stat_s stat;
    int        bad_count = 0;
    int        checks = 0;
    dcc_cke_ctrl u_dcc_cke_ctrl (.clk(clk), .rst(rst), .reset_n(reset_n), .cmd(cmd),
        .init_done(init_done), .stat(stat));
    dcc_ctl_model u_dcc_ctl_model (.clk(clk), .cmd(cmd), .reset_n(reset_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    // One command for one edge, then no-operation
    task automatic go(input logic [3:0] op, input logic cke, input logic [2:0] ba,
        input logic [12:0] a);
        @(negedge clk);
        u_dcc_ctl_model.send(op, cke, ba, a);
        @(negedge clk);
        u_dcc_ctl_model.send(CMD_NOP, cke, 3'h0, 13'h0000);
    endtask : go
    task automatic t_zq;
        int n;
        int w;
        for (int i = 0; i < 2; i++) begin
            init_done = i[0];
            w = i ? ZQ_OPER_CYC : ZQ_INIT_CYC;
            go(CMD_ZQ, 1'b1, 3'h0, 13'h0400);
            chk(stat.zq_busy === 1'b1, "no zq");
            n = 0;
            while (stat.zq_update !== 1'b1 && n < 600) begin
                @(negedge clk);
                n++;
            end
            chk(n == w, "zq window");
        end
        $display("done zq");
    endtask : t_zq
    task automatic t_mrs;
        for (int i = 0; i < MR_COUNT; i++) begin
            go(CMD_MRS, 1'b1, i[2:0], 13'h0a50 + 13'(i));
            chk(stat.mr_we === 1'b1 && stat.mr_sel === i[1:0], "mr sel");
            chk(stat.mr_data === 13'h0a50 + 13'(i), "mr data");
            @(negedge clk);
            chk(stat.mr_we === 1'b0, "nop wrote");
        end
        go(4'h8, 1'b1, 3'h1, 13'h1fff);
        chk(stat.mr_we === 1'b0 && stat.mr_data === 13'h0a53, "des wrote");
        $display("done mrs");
    endtask : t_mrs
    task automatic t_pd;
        chk(stat.idle === 1'b1, "not idle");
        go(CMD_NOP, 1'b0, 3'h0, 13'h0000);
        chk({stat.power_down, stat.active_pd} === 2'b10, "no pd");
        go(CMD_REF, 1'b0, 3'h0, 13'h0000);
        chk(stat.power_down === 1'b1 && stat.self_refresh === 1'b0, "pd ref");
        go(CMD_NOP, 1'b1, 3'h0, 13'h0000);
        chk(stat.power_down === 1'b0 && stat.idle === 1'b0, "no exit");
        repeat (EXIT_CYC - 1) @(negedge clk);
        chk(stat.idle === 1'b0, "early idle");
        @(negedge clk);
        chk(stat.idle === 1'b1, "no settle");
        $display("done pd");
    endtask : t_pd
    task automatic t_sr;
        go(CMD_REF, 1'b0, 3'h0, 13'h0000);
        chk(stat.self_refresh === 1'b1, "no sr");
        @(negedge clk);
        u_dcc_ctl_model.send(4'hf, 1'b1, 3'h0, 13'h0000);
        #1;
        chk(stat.self_refresh === 1'b0, "late exit");
        repeat (EXIT_CYC + 2) @(negedge clk);
        chk(stat.idle === 1'b1, "sr idle");
        $display("done sr");
    endtask : t_sr
    task automatic t_burst;
        int n;
        go(CMD_ACT, 1'b1, 3'h6, 13'h0000);
        go(CMD_ACT, 1'b1, 3'h3, 13'h0000);
        go(CMD_PRE, 1'b1, 3'h6, 13'h0000);
        chk(stat.bank_open === 8'h08 && stat.idle === 1'b0, "act");
        go(CMD_RD, 1'b1, 3'h5, 13'h1000);
        chk(stat.burst_busy === 1'b0, "closed rd");
        go(CMD_RD, 1'b1, 3'h3, 13'h1000);
        n = 0;
        for (int k = 0; k < 8; k++) begin
            n += int'(stat.burst_busy === 1'b1);
            @(negedge clk);
            if (k == 0) u_dcc_ctl_model.send(CMD_WR, 1'b1, 3'h3, 13'h1000);
            if (k == 1) u_dcc_ctl_model.send(CMD_NOP, 1'b1, 3'h0, 13'h0000);
        end
        chk(n == BURST_BL8_CYC, "burst cut");
        go(CMD_RD, 1'b1, 3'h3, 13'h0000);
        n = 0;
        repeat (4) begin
            n += int'(stat.burst_busy === 1'b1);
            @(negedge clk);
        end
        chk(n == BURST_BC4_CYC, "chop length");
        go(CMD_NOP, 1'b0, 3'h0, 13'h0000);
        chk({stat.power_down, stat.active_pd} === 2'b11, "no apd");
        go(CMD_NOP, 1'b1, 3'h0, 13'h0000);
        u_dcc_ctl_model.pin_reset();
        chk(stat.bank_open === 8'h00 && stat.power_down === 1'b0, "pin reset");
        go(CMD_ACT, 1'b1, 3'h2, 13'h0000);
        go(CMD_PRE, 1'b1, 3'h5, 13'h0400);
        chk(stat.bank_open === 8'h00 && stat.idle === 1'b1, "pre all");
        $display("done burst");
    endtask : t_burst
    initial begin
        rst = 1'b1;
        init_done = 1'b0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_zq();
        t_mrs();
        t_pd();
        t_sr();
        t_burst();
        close_out();
    end
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule : tb
`default_nettype wire

// ===== hw/dcc_cke_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module dcc_cke_ctrl
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Active-low reset pin, sampled on the rising clock edge
    input  wire logic      reset_n,
    // Command pins
    input  wire dcc_cmd_s  cmd,
    // Initialization done strap from device sequencer
    input  wire logic      init_done,
    // Status
    output dcc_stat_s      stat
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dcc_state_e           state;
        logic                 cke_prev;
        logic [NUM_BANKS-1:0] bank_open;
        logic [1:0]           mr_sel;
        logic [OP_W-1:0]      mr_data;
        logic                 mr_we;
        logic                 zq_init_seen;
        logic [2:0]           settle;
        logic [CNT_W-1:0]     burst_cnt;
    } dcc_core_s;

    dcc_core_s st;
    dcc_core_s next_st;

    logic [3:0]       op;
    logic             valid_cmd;
    logic             sr_exit_async;
    logic             zq_load;
    logic [CNT_W-1:0] zq_value;
    logic             zq_busy;
    logic             zq_done;
    logic             cke_rise;
    logic             cke_fall;
    logic             cke_hold_low;
    logic             quiet;
    logic             any_open;
    logic             is_idle;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Odt is not part of the decode at all
    assign op        = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign valid_cmd = !cmd.cs_n;
    // Deselect and no-op both fall into the quiet class
    assign quiet     = cmd.cs_n || (op == CMD_NOP);

    assign cke_rise     = !st.cke_prev && cmd.cke;
    assign cke_fall     = st.cke_prev && !cmd.cke;
    assign cke_hold_low = !st.cke_prev && !cmd.cke;
    assign any_open     = |st.bank_open;

    // Combinational wake path: a clock may be stopped in self refresh
    assign sr_exit_async = (st.state == ST_SELF_REF) && cmd.cke;

    assign is_idle = (st.state == ST_IDLE) && !any_open && (st.burst_cnt == '0)
                     && cmd.cke && (st.settle == '0) && !zq_busy;

    // ------------------------------------------------------------
    // Calibration timer
    // ------------------------------------------------------------
    // Window length depends on whether initialization has finished
    assign zq_load  = (st.state == ST_IDLE || st.state == ST_ACTIVE) && !cke_fall
                      && cmd.cke && valid_cmd && (op == CMD_ZQ)
                      && cmd.addr[ADDR_A10];
    assign zq_value = init_done ? CNT_W'(ZQ_OPER_CYC) : CNT_W'(ZQ_INIT_CYC);

    dcc_counter #(
        .W     (CNT_W)
    ) u_zq_timer (
        .clk   (clk),
        .rst   (rst || !reset_n),
        .load  (zq_load),
        .value (zq_value),
        .busy  (zq_busy),
        .done  (zq_done)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.cke_prev = cmd.cke;
        next_st.mr_we    = 1'b0;
        if (st.settle != '0) begin
            next_st.settle = st.settle - 1'b1;
        end
        // Bursts cannot be cut short by any command the controller sends, only by a reset
        if (st.burst_cnt != '0) begin
            next_st.burst_cnt = st.burst_cnt - 1'b1;
        end
        case (st.state)
            ST_IDLE, ST_ACTIVE: begin
                if (cke_fall && quiet) begin
                    if (st.state == ST_ACTIVE || st.burst_cnt != '0) begin
                        next_st.state = ST_PD_ACT;
                    end else begin
                        next_st.state = ST_PD_PRE;
                    end
                end else if (cke_fall && valid_cmd && op == CMD_REF && is_idle == 1'b0
                             && st.state == ST_IDLE && !any_open
                             && st.burst_cnt == '0) begin
                    next_st.state = ST_SELF_REF;
                end else if (!cke_fall && cmd.cke && valid_cmd) begin
                    case (op)
                        CMD_MRS: begin
                            next_st.mr_sel  = cmd.ba[1:0];
                            next_st.mr_data = cmd.addr;
                            next_st.mr_we   = !any_open;
                        end
                        CMD_ACT: begin
                            next_st.bank_open[cmd.ba] = 1'b1;
                            next_st.state             = ST_ACTIVE;
                        end
                        CMD_PRE: begin
                            if (cmd.addr[ADDR_A10]) begin
                                next_st.bank_open = '0;
                            end else begin
                                next_st.bank_open[cmd.ba] = 1'b0;
                            end
                        end
                        CMD_RD, CMD_WR: begin
                            // A new burst is dropped while a running one has not finished
                            if (st.bank_open[cmd.ba] && st.burst_cnt == '0) begin
                                next_st.burst_cnt = cmd.addr[ADDR_A12]
                                    ? CNT_W'(BURST_BL8_CYC) : CNT_W'(BURST_BC4_CYC);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (next_st.state == ST_ACTIVE && next_st.bank_open == '0) begin
                    next_st.state = ST_IDLE;
                end
            end
            ST_PD_ACT, ST_PD_PRE: begin
                // No refresh is issued internally while powered down
                if (cke_rise && quiet) begin
                    next_st.state  = any_open ? ST_ACTIVE : ST_IDLE;
                    next_st.settle = 3'(EXIT_CYC);
                end
            end
            ST_SELF_REF: begin
                if (cke_rise && quiet) begin
                    next_st.state  = ST_IDLE;
                    next_st.settle = 3'(EXIT_CYC);
                end else if (cke_hold_low) begin
                    next_st.state = ST_SELF_REF;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // Reset pin only resets; it issues no command
        if (rst || !reset_n) begin
            st           <= '0;
            st.state     <= ST_IDLE;
            st.mr_data   <= MR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_comb begin
        stat              = '0;
        stat.idle         = is_idle;
        stat.power_down   = (st.state == ST_PD_ACT) || (st.state == ST_PD_PRE);
        stat.active_pd    = (st.state == ST_PD_ACT);
        stat.self_refresh = (st.state == ST_SELF_REF) && !sr_exit_async;
        stat.burst_busy   = (st.burst_cnt != '0);
        stat.zq_busy      = zq_busy;
        stat.zq_update    = zq_done;
        stat.mr_we        = st.mr_we;
        stat.mr_sel       = st.mr_sel;
        stat.mr_data      = st.mr_data;
        stat.bank_open    = st.bank_open;
    end

endmodule : dcc_cke_ctrl

`default_nettype wire

// ===== hw/dcc_counter.sv
`timescale 1ns/100ps
`default_nettype none

module dcc_counter
    import dcc_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // Status
    output logic              busy,
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } dcc_cnt_s;

    dcc_cnt_s st;
    dcc_cnt_s next_st;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (load) begin
            next_st.cnt = value;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
            if (st.cnt == W'(1)) begin
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = (st.cnt != '0);
    assign done = st.done;

endmodule : dcc_counter

`default_nettype wire

// ===== hw/dcc_pkg.sv
package dcc_pkg;

    // ------------------------------------------------------------
    // Command encoding {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_ZQ   = 4'h6;
    localparam logic [3:0] CMD_NOP  = 4'h7;

    // ------------------------------------------------------------
    // Field positions and sizes
    // ------------------------------------------------------------
    localparam int NUM_BANKS     = 8;
    localparam int BANK_W        = 3;
    localparam int MR_COUNT      = 4;
    localparam int OP_W          = 13;
    localparam int ADDR_A10      = 10;
    localparam int ADDR_A12      = 12;

    // ------------------------------------------------------------
    // Timing counts, in clock cycles, and the counter width in bits
    // ------------------------------------------------------------
    localparam int BURST_BL8_CYC = 4;
    localparam int BURST_BC4_CYC = 2;
    localparam int ZQ_INIT_CYC   = 512;
    localparam int ZQ_OPER_CYC   = 256;
    localparam int CKE_MIN_CYC   = 3;
    localparam int EXIT_CYC      = 4;
    localparam int CNT_W         = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [OP_W-1:0] MR_RESET = 13'h0000;

    typedef enum {
        ST_IDLE,
        ST_ACTIVE,
        ST_PD_ACT,
        ST_PD_PRE,
        ST_SELF_REF
    } dcc_state_e;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              cke;
        logic              odt;
        logic [BANK_W-1:0] ba;
        logic [OP_W-1:0]   addr;
    } dcc_cmd_s;

    typedef struct packed {
        logic              idle;
        logic              power_down;
        logic              active_pd;
        logic              self_refresh;
        logic              burst_busy;
        logic              zq_busy;
        logic              zq_update;
        logic              mr_we;
        logic [1:0]        mr_sel;
        logic [OP_W-1:0]   mr_data;
        logic [NUM_BANKS-1:0] bank_open;
    } dcc_stat_s;

endpackage : dcc_pkg
